// ===== pmc_wake_status.sv
// wake-cause status, power-event output shaping and ready indication
// assumes synchronous host strobes on core_clk_i and single-cycle event pulses
`timescale 1ns/1ps
`include "pmc_wake_params.svh"

// Overview of operation
// - wake cause field: 00 none, 01 energy, 10 wake frame, 11 both events.
// - status bits clear only on writing one; writing zero keeps them.
// - status clear writes are ignored until the ready indication is set.
// - a status bit clears only when its event source has also cleared.
// - pulse select set gives a 50 ms output pulse, restarted by each enabled wake event.
// - pulse select clear holds output active after a wake event until deactivated.
// - static output drops when status bits or the matching enable are cleared.
// - polarity bit picks active-high when set, active-low when clear.
// - open-drain output ignores polarity and is always active low.
// - external power-event output asserts only while output enable is set.
// - output enable has no effect on the internal wake-event interrupt.
// - ready sets once operation settles after power-up and after each wake.
// - the control register reads back correctly in every power state.
// - power state 00 normal, 01 wake frame, 10 energy detect, 11 reserved.
// - drive type clear gives open-drain output, set gives push-pull.
// - enabled wake events raise the interrupt whatever the output enable.
module pmc_wake_status #(
  parameter int unsigned PULSE_CYCLES =
    (`PMC_PULSE_MS * `PMC_NS_PER_MS) / `PMC_CLK_PERIOD_NS, // 50 ms, round down
  parameter int unsigned SETTLE_CYCLES =
    (`PMC_SETTLE_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS, // round up
  parameter int unsigned PULSE_W = 24, // width of the pulse counter
  parameter int unsigned SETTLE_W = 16 // width of the settle counter
) (
  input wire logic core_clk_i, // core clock, 250 MHz
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic ce_i, // clock enable, freezes all state when low
  input wire pmc_wake_pkg::pmc_bus_req_s bus_i, // host read/write request
  output logic [31:0] rdata_o, // read data, registered
  output logic rvalid_o, // read data valid, one cycle
  input wire pmc_wake_pkg::pmc_event_s event_i, // wake event pulses
  input wire pmc_wake_pkg::pmc_event_s src_pending_i, // event sources still pending
  input wire logic wake_req_i, // host wake request pulse
  output logic power_event_o, // power-event pin output value
  output logic power_event_oe_o, // power-event pin drive enable
  output logic wake_event_interrupt_o, // internal wake-event interrupt, level
  output logic [1:0] power_state_select_o, // current power state field
  output logic ready_o // device ready indication
);
  import pmc_wake_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    pmc_pwr_e pwr;
    logic [SETTLE_W-1:0] settle_cnt;
    logic [1:0] mode;
    logic [1:0] status;
    logic pulse_sel;
    logic pol;
    logic out_en;
    logic push_pull;
    logic energy_detect_enable;
    logic lan_wake_enable;
    logic pulse_run;
    logic [PULSE_W-1:0] pulse_cnt;
    logic [31:0] rdata;
    logic rvalid;
  } pmc_state_s;

  pmc_state_s s_q;
  pmc_state_s s_d;
  logic ready;
  logic sel;
  logic wr;
  logic [1:0] en_vec;
  logic [1:0] hit_vec;
  logic static_hit;
  logic active;
  logic [1:0] clr_req;
  logic [31:0] rd_word;

  // ****************************************************************
  // decode
  // ****************************************************************
  // the interrupt follows status and enables only, never the output enable
  assign ready = (s_q.pwr == PMC_ST_ACTIVE);
  assign sel = (bus_i.addr == `PMC_CTRL_OFFSET);
  assign wr = bus_i.wr && sel;
  assign en_vec = {s_q.lan_wake_enable, s_q.energy_detect_enable};
  assign hit_vec = event_i & en_vec;
  assign static_hit = |(s_q.status & en_vec);
  assign active = s_q.out_en && (s_q.pulse_sel ? s_q.pulse_run : static_hit);
  // a clear needs ready, a written one, and a quiet source
  assign clr_req = (wr && ready) ?
    (bus_i.wdata[`PMC_STAT_HI_BIT:`PMC_STAT_LO_BIT] & ~src_pending_i) : 2'h0;

  // register image; readable in every power state
  always_comb begin
    rd_word = 32'h0;
    rd_word[`PMC_READY_BIT] = ready;
    rd_word[`PMC_OUT_EN_BIT] = s_q.out_en;
    rd_word[`PMC_POL_BIT] = s_q.pol;
    rd_word[`PMC_PULSE_SEL_BIT] = s_q.pulse_sel;
    rd_word[`PMC_STAT_HI_BIT:`PMC_STAT_LO_BIT] = s_q.status;
    rd_word[`PMC_DRIVE_BIT] = s_q.push_pull;
    rd_word[`PMC_ENERGY_DETECT_ENABLE_BIT] = s_q.energy_detect_enable;
    rd_word[`PMC_LAN_WAKE_ENABLE_BIT] = s_q.lan_wake_enable;
    rd_word[`PMC_MODE_HI_BIT:`PMC_MODE_LO_BIT] = s_q.mode;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // read answer, valid whatever the power state
    s_d.rvalid = bus_i.rd && sel;
    s_d.rdata = (bus_i.rd && sel) ? rd_word : `PMC_RDATA_RESET;
    // configuration bits stay writable while asleep so wake can be set up
    if (wr) begin
      s_d.out_en = bus_i.wdata[`PMC_OUT_EN_BIT];
      s_d.pol = bus_i.wdata[`PMC_POL_BIT];
      s_d.pulse_sel = bus_i.wdata[`PMC_PULSE_SEL_BIT];
      s_d.push_pull = bus_i.wdata[`PMC_DRIVE_BIT];
      s_d.energy_detect_enable = bus_i.wdata[`PMC_ENERGY_DETECT_ENABLE_BIT];
      s_d.lan_wake_enable = bus_i.wdata[`PMC_LAN_WAKE_ENABLE_BIT];
    end
    // enabled events set status; set wins over a clear in the same cycle
    s_d.status = (s_q.status & ~clr_req) | hit_vec;
    // pulse: restart on each enabled event, run the full length
    if (|hit_vec) begin
      s_d.pulse_run = 1'b1;
      s_d.pulse_cnt = PULSE_W'(PULSE_CYCLES - 1);
    end else if (s_q.pulse_run) begin
      if (s_q.pulse_cnt == '0) begin
        s_d.pulse_run = 1'b0;
      end else begin
        s_d.pulse_cnt = s_q.pulse_cnt - 1'b1;
      end
    end
    // power sequencing
    unique case (s_q.pwr)
      PMC_ST_SETTLE: begin
        if (s_q.settle_cnt == '0) begin
          s_d.pwr = PMC_ST_ACTIVE;
        end else begin
          s_d.settle_cnt = s_q.settle_cnt - 1'b1;
        end
      end
      PMC_ST_ACTIVE: begin
        // reserved power state is not taken; the field keeps its value
        if (wr && (bus_i.wdata[`PMC_MODE_HI_BIT:`PMC_MODE_LO_BIT] == `PMC_MODE_WOL ||
            bus_i.wdata[`PMC_MODE_HI_BIT:`PMC_MODE_LO_BIT] == `PMC_MODE_ED)) begin
          s_d.mode = bus_i.wdata[`PMC_MODE_HI_BIT:`PMC_MODE_LO_BIT];
          s_d.pwr = PMC_ST_SLEEP;
        end
      end
      PMC_ST_SLEEP: begin
        // host wake or an enabled event returns the core to normal operation
        if (wake_req_i || (|hit_vec)) begin
          s_d.mode = `PMC_MODE_NORMAL;
          s_d.pwr = PMC_ST_SETTLE;
          s_d.settle_cnt = SETTLE_W'(SETTLE_CYCLES - 1);
        end
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // reset starts a settle period so ready rises only after it
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.pwr <= PMC_ST_SETTLE;
      s_q.settle_cnt <= SETTLE_W'(SETTLE_CYCLES - 1);
      s_q.mode <= `PMC_MODE_NORMAL;
      s_q.status <= `PMC_STAT_NONE;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // open-drain pulls low only while active; push-pull always drives
  assign power_event_oe_o = s_q.push_pull ? 1'b1 : active;
  assign power_event_o = s_q.push_pull ? (s_q.pol ? active : ~active) : 1'b0;
  assign wake_event_interrupt_o = static_hit;
  assign power_state_select_o = s_q.mode;
  assign ready_o = ready;
  assign rdata_o = s_q.rdata;
  assign rvalid_o = s_q.rvalid;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_pulse_start;
    ce_i && s_q.pulse_sel && (|hit_vec);
  endsequence

  sequence s_pulse_hold;
    s_q.pulse_run [*3];
  endsequence

  property p_status_set;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && hit_vec[0]) |=> s_q.status[0];
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("energy event did not set status");

  property p_zero_write_keeps;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (wr && bus_i.wdata[`PMC_STAT_LO_BIT] == 1'b0 && s_q.status[0]) |=> s_q.status[0];
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps)
    else $error("writing zero cleared a status bit");

  property p_clear_needs_ready;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (!ready && s_q.status[1]) |=> s_q.status[1];
  endproperty
  a_clear_needs_ready: assert property (p_clear_needs_ready)
    else $error("status cleared while not ready");

  property p_clear_needs_quiet_source;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (src_pending_i.energy && s_q.status[0]) |=> s_q.status[0];
  endproperty
  a_clear_needs_quiet_source: assert property (p_clear_needs_quiet_source)
    else $error("status cleared while source pending");

  property p_pulse_runs;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_pulse_start |=> (s_q.pulse_cnt == PULSE_W'(PULSE_CYCLES - 1)) ##0 s_pulse_hold;
  endproperty
  a_pulse_runs: assert property (p_pulse_runs)
    else $error("wake pulse did not start at full length");

  property p_static_holds;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (!s_q.pulse_sel && active && !bus_i.wr) |=> active;
  endproperty
  a_static_holds: assert property (p_static_holds)
    else $error("static power event dropped without a write");

  property p_pin_level;
    @(posedge core_clk_i) disable iff (!rstn_i)
      active |-> (power_event_o == (s_q.push_pull && s_q.pol)) && power_event_oe_o;
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("power event pin shows the wrong active level");

  property p_out_enable_gates;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !s_q.out_en |-> (s_q.push_pull ? (power_event_o == ~s_q.pol) : !power_event_oe_o);
  endproperty
  a_out_enable_gates: assert property (p_out_enable_gates)
    else $error("power event asserted while output disabled");

  property p_irq_ignores_enable;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (s_q.status[1] && s_q.lan_wake_enable) |-> wake_event_interrupt_o;
  endproperty
  a_irq_ignores_enable: assert property (p_irq_ignores_enable)
    else $error("wake interrupt missing");

  property p_ready_after_settle;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && s_q.pwr == PMC_ST_SETTLE && s_q.settle_cnt == '0) |=> ready_o;
  endproperty
  a_ready_after_settle: assert property (p_ready_after_settle)
    else $error("ready not set after settling");

  // power state field of the write data, shared by the mode checks below
  logic [1:0] wr_mode;
  assign wr_mode = bus_i.wdata[`PMC_MODE_HI_BIT:`PMC_MODE_LO_BIT];

  // a valid clear must really take, not only be refused when invalid
  property p_clear_takes;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && ready && wr && bus_i.wdata[`PMC_STAT_LO_BIT] && !src_pending_i.energy &&
       !event_i.energy) |=> !s_q.status[0];
  endproperty
  a_clear_takes: assert property (p_clear_takes)
    else $error("valid status clear was not applied");

  property p_read_answer;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && bus_i.rd && sel) |=>
        (rvalid_o && rdata_o[`PMC_STAT_HI_BIT:`PMC_STAT_LO_BIT] == $past(s_q.status));
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("register read answer missing or wrong");

  property p_sleep_entry;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && ready && wr && (wr_mode == `PMC_MODE_WOL || wr_mode == `PMC_MODE_ED)) |=>
        (!ready_o && power_state_select_o == $past(wr_mode));
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep request did not take effect");

  property p_reserved_mode_kept;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && ready && wr && wr_mode == `PMC_MODE_RSVD) |=> $stable(power_state_select_o);
  endproperty
  a_reserved_mode_kept: assert property (p_reserved_mode_kept)
    else $error("reserved power state was taken");

endmodule

// ===== pmc_wake_params.svh
// constants for the wake-cause status and power-event output block
// assumes a 250 MHz core clock; included by the package and the design file
`ifndef PMC_WAKE_PARAMS_SVH
`define PMC_WAKE_PARAMS_SVH

// ****************************************************************
// register placement
// ****************************************************************
`define PMC_ADDR_W 8
`define PMC_CTRL_OFFSET 8'h84

// ****************************************************************
// field positions inside the power management control register
// ****************************************************************
`define PMC_READY_BIT 0
`define PMC_OUT_EN_BIT 1
`define PMC_POL_BIT 2
`define PMC_PULSE_SEL_BIT 3
`define PMC_STAT_LO_BIT 4
`define PMC_STAT_HI_BIT 5
`define PMC_DRIVE_BIT 6
`define PMC_ENERGY_DETECT_ENABLE_BIT 8
`define PMC_LAN_WAKE_ENABLE_BIT 9
`define PMC_MODE_LO_BIT 12
`define PMC_MODE_HI_BIT 13

// ****************************************************************
// encodings and reset values
// ****************************************************************
`define PMC_MODE_NORMAL 2'h0
`define PMC_MODE_WOL 2'h1
`define PMC_MODE_ED 2'h2
`define PMC_MODE_RSVD 2'h3
`define PMC_STAT_NONE 2'h0
`define PMC_BIT_RESET 1'h0
`define PMC_RDATA_RESET 32'h0

// ****************************************************************
// timing
// ****************************************************************
`define PMC_CLK_PERIOD_NS 4
`define PMC_PULSE_MS 50
`define PMC_NS_PER_MS 1000000
`define PMC_SETTLE_NS 1000

`endif

// ===== pmc_wake_pkg.sv
// types shared by the wake-cause status and power-event output block
// assumes pmc_wake_params.svh is on the include path
`include "pmc_wake_params.svh"

package pmc_wake_pkg;

  // host access to the register, one request per cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`PMC_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } pmc_bus_req_s;

  // one bit per wake source: bit 0 energy detect, bit 1 wake frame or magic packet
  typedef struct packed {
    logic wake_frame;
    logic energy;
  } pmc_event_s;

  // power sequencing of the device core
  typedef enum logic [1:0] {
    PMC_ST_SETTLE,
    PMC_ST_ACTIVE,
    PMC_ST_SLEEP
  } pmc_pwr_e;

endpackage

// ===== pmc_wake_rx.sv
// system-side receiver of the power-event pin, with a pull-up on the wire
// assumes the device splits the pin into a value and a drive enable
`timescale 1ns/1ps
module pmc_wake_rx (
  input wire logic power_event_i, // pin value from the device
  input wire logic power_event_oe_i, // pin drive enable from the device
  output logic pin_level_o // resolved wire level
);
  // an undriven wire floats to the pull-up, so open-drain can only pull low
  assign pin_level_o = power_event_oe_i ? power_event_i : 1'b1;
endmodule

// ===== tb.sv
// self-checking bench for the wake-cause status and power-event output block
// assumes short pulse and settle counts, inputs driven on the falling edge
`timescale 1ns/1ps
`include "pmc_wake_params.svh"
module tb;
  import pmc_wake_pkg::*;
  localparam int unsigned PULSE = 20;
  localparam int unsigned SETTLE = 4;
  localparam logic [7:0] CTRL = `PMC_CTRL_OFFSET;
  typedef struct packed {
    logic [31:0] cfg;
    logic out;
    logic oe;
  } pmc_row_s;
  logic core_clk_i, rstn_i, ce_i, wake_req_i, pin_level, rvalid, pe, pe_oe, irq, ready, ok;
  logic [1:0] pss;
  logic [31:0] rdata, d;
  pmc_bus_req_s bus;
  pmc_event_s ev, pend;
  int n_errors, n_compared, cycles, n;
  pmc_row_s rows[6];

  pmc_wake_status #(.PULSE_CYCLES(PULSE), .SETTLE_CYCLES(SETTLE)) pmc_wake_status_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .bus_i(bus),
    .rdata_o(rdata), .rvalid_o(rvalid), .event_i(ev), .src_pending_i(pend),
    .wake_req_i(wake_req_i), .power_event_o(pe), .power_event_oe_o(pe_oe),
    .wake_event_interrupt_o(irq), .power_state_select_o(pss), .ready_o(ready));
  pmc_wake_rx pmc_wake_rx_inst (
    .power_event_i(pe), .power_event_oe_i(pe_oe), .pin_level_o(pin_level));

  // ****************************************************************
  // clock and hang guard
  // ****************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      results();
    end
  end

  // ****************************************************************
  // compare and bus tasks
  // ****************************************************************
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] w);
    bus.wr = 1'b1;
    bus.addr = CTRL;
    bus.wdata = w;
    @(negedge core_clk_i);
    bus.wr = 1'b0;
    // idle cycle so a following request never re-raises the strobe in the same step
    @(negedge core_clk_i);
  endtask
  // the answer stands only in the cycle right after the read edge, then one idle cycle
  task automatic rd(input logic [7:0] a);
    bus.rd = 1'b1;
    bus.addr = a;
    @(negedge core_clk_i);
    bus.rd = 1'b0;
    ok = (rvalid === 1'b1);
    d = rdata;
    @(negedge core_clk_i);
  endtask
  task automatic chk_rd(input logic [31:0] exp);
    rd(CTRL);
    chk_bit(ok, 1'b1);
    chk_word(d, exp);
    chk_bit(rvalid, 1'b0);
    chk_word(rdata, 32'h0);
  endtask
  task automatic fire(input logic [1:0] e);
    ev = pmc_event_s'(e);
    @(negedge core_clk_i);
    ev = '0;
  endtask
  task automatic wait_ready();
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rstn_i = 1'b0;
    ce_i = 1'b1;
    wake_req_i = 1'b0;
    bus = '0;
    ev = '0;
    pend = '0;
    cycles = 0;
    n_errors = 0;
    n_compared = 0;
    // pin table: out enable bit 1, polarity bit 2, push-pull bit 6, energy enable
    rows = '{'{32'h146, 1'b1, 1'b1}, '{32'h142, 1'b0, 1'b1}, '{32'h106, 1'b0, 1'b1},
             '{32'h102, 1'b0, 1'b1}, '{32'h144, 1'b0, 1'b1}, '{32'h100, 1'b0, 1'b0}};
    repeat (4) @(negedge core_clk_i);
    chk_bit(ready, 1'b0);
    chk_bit(pe_oe, 1'b0);
    rstn_i = 1'b1;
    wait_ready();
    chk_bit(n == SETTLE, 1'b1);
    chk_rd(32'h1);
    rd(8'h80);
    chk_bit(ok, 1'b0);
    $display("test reset done");
    // static output shaping, one energy event per row
    foreach (rows[i]) begin
      wr(rows[i].cfg);
      fire(2'b01);
      chk_bit(irq, 1'b1);
      chk_bit(pe, rows[i].out);
      chk_bit(pe_oe, rows[i].oe);
      chk_bit(pin_level, rows[i].oe ? rows[i].out : 1'b1);
      chk_rd(rows[i].cfg | 32'h11);
      wr(rows[i].cfg | 32'h10);
      chk_bit(irq, 1'b0);
      chk_bit(pe_oe, rows[i].cfg[6]);
      chk_bit(pe, rows[i].cfg[6] & ~rows[i].cfg[2]);
    end
    $display("test pin table done");
    // both causes, zero writes, pending source blocks its bit
    wr(32'h300);
    fire(2'b11);
    chk_rd(32'h331);
    wr(32'h300);
    chk_rd(32'h331);
    pend = pmc_event_s'(2'b01);
    wr(32'h330);
    chk_rd(32'h311);
    pend = '0;
    wr(32'h310);
    chk_rd(32'h301);
    $display("test status clear done");
    // pulse mode, push-pull active high
    wr(32'h14e);
    fire(2'b01);
    n = 0;
    repeat (PULSE + 10) begin
      if (pe === 1'b1) n++;
      @(negedge core_clk_i);
    end
    chk_bit(n == PULSE, 1'b1);
    wr(32'h15e);
    $display("test pulse done");
    // sleep, wake on a frame, clear refused until ready; host reads only this register
    wr(32'h1300);
    chk_bit(ready, 1'b0);
    chk_word({30'h0, pss}, 32'h1);
    chk_rd(32'h1300);
    fire(2'b10);
    chk_word({30'h0, pss}, 32'h0);
    wr(32'h320);
    wait_ready();
    chk_rd(32'h321);
    wr(32'h320);
    chk_rd(32'h301);
    wr(32'h2300);
    chk_word({30'h0, pss}, 32'h2);
    wake_req_i = 1'b1;
    @(negedge core_clk_i);
    wake_req_i = 1'b0;
    wait_ready();
    chk_bit(ready, 1'b1);
    wr(32'h3300);
    chk_word({30'h0, pss}, 32'h0);
    $display("test power states done");
    // clock enable low freezes state: an event in that cycle is lost
    fire(2'b01);
    ce_i = 1'b0;
    @(negedge core_clk_i);
    fire(2'b10);
    ce_i = 1'b1;
    chk_rd(32'h311);
    // reset in mid-run clears status and ready; the register still reads while settling
    rstn_i = 1'b0;
    @(negedge core_clk_i);
    chk_bit(irq, 1'b0);
    chk_bit(ready, 1'b0);
    chk_bit(pe_oe, 1'b0);
    chk_word({30'h0, pss}, 32'h0);
    rstn_i = 1'b1;
    chk_rd(32'h0);
    wait_ready();
    chk_bit(ready, 1'b1);
    $display("test clock enable and reset done");
    results();
  end
endmodule
